// ### include/wdt_pkg.sv
/*
 * Constants shared by the watchdog block: register address, control
 * field positions, reset values, mode codes and tick counts.
 * Assumes an 8-bit special-function-register bus and a single clock.
 */
package wdt_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] WDT_CTRL_ADDR = 8'hAA;

    localparam int WDT_BIT_RUN = 7;
    localparam int WDT_BIT_CLR = 6;
    localparam int WDT_BIT_TOF = 5;
    localparam int WDT_BIT_LPRUN = 4;
    localparam int WDT_BIT_RSTF = 3;
    localparam int WDT_PS_MSB = 2;
    localparam int WDT_PS_LSB = 0;

    localparam logic [2:0] WDT_PS_POR = 3'h7;
    localparam logic [7:0] WDT_RDATA_RST = 8'h00;

    // ----------------------------------------------------------------
    // mode configuration codes
    // ----------------------------------------------------------------
    localparam logic [3:0] WDT_MODE_GP = 4'hF;
    localparam logic [3:0] WDT_MODE_STOP_LP = 4'h5;

    // ----------------------------------------------------------------
    // counts in prescaled or raw oscillator ticks
    // ----------------------------------------------------------------
    localparam int WDT_TIMEOUT_TICKS = 64;
    localparam int WDT_GRACE_TICKS = 512;
    localparam int WDT_CNT_W = $clog2(WDT_TIMEOUT_TICKS);
    localparam int WDT_GRACE_W = $clog2(WDT_GRACE_TICKS) + 1;

    typedef logic [2:0] wdt_ps_t;
endpackage

// ### include/wdt_tick_if.sv
/*
 * Carrier between the watchdog core and its oscillator prescaler.
 * Assumes all signals are synchronous to the core clock.
 */
interface wdt_tick_if;
    logic lso_tick;
    logic clear;
    logic [2:0] select;
    logic div_tick;

    modport core (output lso_tick, output clear, output select, input div_tick);
    modport presc (input lso_tick, input clear, input select, output div_tick);
endinterface

// ### rtl/wdt_prescaler.sv
/*
 * Prescaler dividing oscillator ticks by 1, 4, 8 ... 256.
 * Assumes lso_tick is a one-cycle pulse per oscillator period.
 */
module wdt_prescaler
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    wdt_tick_if.presc tick
);
    import wdt_pkg::*;

    // ----------------------------------------------------------------
    // terminal count
    // ----------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] term;
    wire at_term = (cnt_reg == term);

    always_comb
    begin
        case (tick.select)
            3'h0: term = 8'h00;
            3'h1: term = 8'h03;
            3'h2: term = 8'h07;
            3'h3: term = 8'h0F;
            3'h4: term = 8'h1F;
            3'h5: term = 8'h3F;
            3'h6: term = 8'h7F;
            default: term = 8'hFF;
        endcase
    end

    assign tick.div_tick = tick.lso_tick && at_term && !tick.clear;

    always_comb
    begin
        if (tick.clear)
            cnt_next = 8'h00;
        else if (tick.lso_tick)
            cnt_next = at_term ? 8'h00 : cnt_reg + 8'h01;
        else
            cnt_next = cnt_reg;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// ### rtl/wdt_top.sv
/*
 * Watchdog timer: time-out reset timer or general-purpose periodic
 * timer, controlled through one timed-access-protected SFR.
 * Assumes the oscillator tick, low-power levels, unlock window and
 * configuration field are synchronous to I_CLK. I_POR_N is asserted
 * only by power-on reset, together with I_RESET_N.
 */
module wdt_top
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_POR_N,
    input wire logic I_LSO_TICK,
    input wire logic [3:0] I_MODE_CONFIG,
    input wire logic I_IDLE,
    input wire logic I_POWER_DOWN,
    input wire logic I_TA_OPEN,
    input wire logic I_IRQ_ENABLE,
    input wire logic I_GLOBAL_IRQ_ENABLE,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    output logic O_IRQ,
    output logic O_WAKEUP,
    output logic O_SYS_RESET
);
    import wdt_pkg::*;

    // ----------------------------------------------------------------
    // control register state
    // ----------------------------------------------------------------
    logic run_reg;
    logic clr_pend_reg;
    logic tof_reg;
    logic lprun_reg;
    logic rstf_reg;
    wdt_ps_t ps_reg;
    logic [7:0] rdata_reg;

    // ----------------------------------------------------------------
    // counting state
    // ----------------------------------------------------------------
    logic [WDT_CNT_W-1:0] cnt_reg;
    logic [WDT_CNT_W-1:0] cnt_next;
    logic grace_on_reg;
    logic [WDT_GRACE_W-1:0] grace_reg;
    logic [WDT_GRACE_W-1:0] grace_next;
    logic lp_prev_reg;
    logic sys_rst_reg;
    logic wake_reg;

    wdt_tick_if tick ();

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire ctrl_hit = (I_SFR_ADDR == WDT_CTRL_ADDR);
    wire ctrl_wr = I_SFR_WR && ctrl_hit && I_TA_OPEN;
    wire wr_clr = ctrl_wr && I_SFR_WDATA[WDT_BIT_CLR];

    wire gp_mode = (I_MODE_CONFIG == WDT_MODE_GP);
    wire low_power = I_IDLE || I_POWER_DOWN;
    wire lp_change = (low_power != lp_prev_reg);

    wire gp_run = run_reg && (!low_power || lprun_reg);
    wire rst_run = !low_power || (I_MODE_CONFIG != WDT_MODE_STOP_LP);
    wire counting = gp_mode ? gp_run : rst_run;

    // clearing completes at the next oscillator tick, as the real
    // counter lives on that clock; reads show it still pending
    wire clr_done = clr_pend_reg && I_LSO_TICK;
    wire cnt_clear = clr_done || lp_change;

    wire cnt_max = (cnt_reg == WDT_CNT_W'(WDT_TIMEOUT_TICKS - 1));
    wire timeout = counting && tick.div_tick && cnt_max;

    // grace end after 512 oscillator clocks
    wire grace_end = grace_on_reg && I_LSO_TICK
        && (grace_reg == WDT_GRACE_W'(WDT_GRACE_TICKS - 1));

    assign tick.lso_tick = I_LSO_TICK && counting;
    assign tick.clear = cnt_clear;
    assign tick.select = ps_reg;

    wdt_prescaler u_presc
    (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .tick(tick)
    );

    wire [7:0] ctrl_value = {run_reg, clr_pend_reg, tof_reg, lprun_reg,
        rstf_reg, ps_reg};

    // ----------------------------------------------------------------
    // next-state
    // ----------------------------------------------------------------
    // counter wraps and keeps going
    always_comb
    begin
        if (cnt_clear)
            cnt_next = '0;
        else if (counting && tick.div_tick)
            cnt_next = cnt_reg + WDT_CNT_W'(1);
        else
            cnt_next = cnt_reg;
    end

    always_comb
    begin
        if (!grace_on_reg)
            grace_next = '0;
        else if (I_LSO_TICK)
            grace_next = grace_reg + WDT_GRACE_W'(1);
        else
            grace_next = grace_reg;
    end

    // ----------------------------------------------------------------
    // software bits (cleared by any reset)
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            run_reg <= 1'b0;
            lprun_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            run_reg <= I_SFR_WDATA[WDT_BIT_RUN];
            lprun_reg <= I_SFR_WDATA[WDT_BIT_LPRUN];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            clr_pend_reg <= 1'b0;
        else if (wr_clr)
            clr_pend_reg <= 1'b1;
        else if (clr_done)
            clr_pend_reg <= 1'b0;
    end

    // flag set wins over software clear
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            tof_reg <= 1'b0;
        else if (timeout)
            tof_reg <= 1'b1;
        else if (ctrl_wr)
            tof_reg <= I_SFR_WDATA[WDT_BIT_TOF];
    end

    // ----------------------------------------------------------------
    // bits kept across all but power-on reset
    // ----------------------------------------------------------------
    // reset flag set by own reset
    always_ff @(posedge I_CLK or negedge I_POR_N)
    begin
        if (!I_POR_N)
            rstf_reg <= 1'b0;
        else if (grace_end)
            rstf_reg <= 1'b1;
        else if (ctrl_wr)
            rstf_reg <= I_SFR_WDATA[WDT_BIT_RSTF];
    end

    always_ff @(posedge I_CLK or negedge I_POR_N)
    begin
        if (!I_POR_N)
            ps_reg <= WDT_PS_POR;
        else if (ctrl_wr)
            ps_reg <= I_SFR_WDATA[WDT_PS_MSB:WDT_PS_LSB];
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    // counter zero on reset
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            cnt_reg <= '0;
            grace_reg <= '0;
            lp_prev_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            grace_reg <= grace_next;
            lp_prev_reg <= low_power;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            grace_on_reg <= 1'b0;
        else if (wr_clr || grace_end)
            grace_on_reg <= 1'b0;
        else if (timeout && !gp_mode)
            grace_on_reg <= 1'b1;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // system reset pulse, wake pulse
    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            sys_rst_reg <= 1'b0;
            wake_reg <= 1'b0;
            rdata_reg <= WDT_RDATA_RST;
        end
        else
        begin
            sys_rst_reg <= grace_end;
            wake_reg <= timeout && low_power;
            rdata_reg <= ctrl_hit ? ctrl_value : 8'h00;
        end
    end

    assign O_IRQ = tof_reg && I_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE;
    assign O_WAKEUP = wake_reg;
    assign O_SYS_RESET = sys_rst_reg;
    assign O_SFR_RDATA = rdata_reg;
endmodule

// ### verif/wdt_props.sv
/*
 * Assertion checker for the watchdog top level.
 * Assumes it is bound onto wdt_top and sees only its ports.
 */
module wdt_props
    import wdt_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_POR_N,
    input wire logic I_LSO_TICK,
    input wire logic [3:0] I_MODE_CONFIG,
    input wire logic I_IDLE,
    input wire logic I_POWER_DOWN,
    input wire logic I_TA_OPEN,
    input wire logic I_IRQ_ENABLE,
    input wire logic I_GLOBAL_IRQ_ENABLE,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic O_IRQ,
    input wire logic O_WAKEUP,
    input wire logic O_SYS_RESET
);
    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    // two reads in a row, no unlocked write between, reset long gone
    sequence s_quiet;
        I_SFR_ADDR == WDT_CTRL_ADDR && $past(I_SFR_ADDR) == WDT_CTRL_ADDR &&
        !$past(I_SFR_WR && I_TA_OPEN) && $past(I_RESET_N) && $past(I_RESET_N, 2);
    endsequence

    a_irq_gated: assert property (O_IRQ |-> I_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE)
        else $error("irq raised without both enables");
    a_irq_from_flag: assert property ($past(I_SFR_ADDR) == WDT_CTRL_ADDR
        && O_SFR_RDATA[WDT_BIT_TOF] && !$past(I_SFR_WR && I_TA_OPEN)
        && I_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE |-> O_IRQ) else $error("irq missing");
    a_prescale_kept: assert property (s_quiet |=> O_SFR_RDATA[2:0] == $past(O_SFR_RDATA[2:0]))
        else $error("prescale changed without unlocked write");
    a_flag_sticky: assert property (s_quiet |=> !$fell(O_SFR_RDATA[WDT_BIT_TOF]))
        else $error("time-out flag cleared by hardware");
    a_rstflag_sticky: assert property (s_quiet |=> !$fell(O_SFR_RDATA[WDT_BIT_RSTF]))
        else $error("reset flag lost without write");
    a_clear_pending: assert property (I_SFR_WR && I_TA_OPEN && I_SFR_ADDR == WDT_CTRL_ADDR
        && I_SFR_WDATA[WDT_BIT_CLR] && !I_LSO_TICK ##1 I_SFR_ADDR == WDT_CTRL_ADDR
        |=> O_SFR_RDATA[WDT_BIT_CLR]) else $error("clear not shown pending");
    a_wake_pulse: assert property (O_WAKEUP |=> !O_WAKEUP)
        else $error("wakeup longer than one cycle");
    a_wake_lowpower: assert property (O_WAKEUP |-> $past(I_IDLE || I_POWER_DOWN))
        else $error("wakeup outside low power");
    a_sysrst_pulse: assert property (O_SYS_RESET |=> !O_SYS_RESET)
        else $error("system reset longer than one cycle");
    a_sysrst_mode: assert property (O_SYS_RESET |-> I_MODE_CONFIG != WDT_MODE_GP)
        else $error("system reset in general mode");

    c_sysrst: cover property (O_SYS_RESET);
    c_wake: cover property (O_WAKEUP);
    c_irq: cover property (O_IRQ);
endmodule

bind wdt_top wdt_props wdt_props_i (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_POR_N(I_POR_N),
    .I_LSO_TICK(I_LSO_TICK), .I_MODE_CONFIG(I_MODE_CONFIG), .I_IDLE(I_IDLE),
    .I_POWER_DOWN(I_POWER_DOWN), .I_TA_OPEN(I_TA_OPEN), .I_IRQ_ENABLE(I_IRQ_ENABLE),
    .I_GLOBAL_IRQ_ENABLE(I_GLOBAL_IRQ_ENABLE), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR),
    .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .O_IRQ(O_IRQ),
    .O_WAKEUP(O_WAKEUP), .O_SYS_RESET(O_SYS_RESET));

// ### verif/tb.sv
/*
 * Self-checking bench for the watchdog top level.
 * Assumes nothing beyond the design; the bench drives every input itself.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    logic clk, rst_n, por_n, tick, idle, pd, ta, ie, ge, wr, irq, wake, sysrst;
    logic [3:0] mode;
    logic [7:0] addr, wdata, rdata;
    int err_total = 0;
    int num_checks = 0;
    int wakes = 0;
    int resets = 0;

    wdt_top wdt_top_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_POR_N(por_n), .I_LSO_TICK(tick),
        .I_MODE_CONFIG(mode), .I_IDLE(idle), .I_POWER_DOWN(pd), .I_TA_OPEN(ta),
        .I_IRQ_ENABLE(ie), .I_GLOBAL_IRQ_ENABLE(ge), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .O_IRQ(irq), .O_WAKEUP(wake),
        .O_SYS_RESET(sysrst));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (wake === 1'b1) wakes++;
        if (sysrst === 1'b1) resets++;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
    endtask

    task automatic wrc(input logic [7:0] d, input logic t);
        @(posedge clk);
        addr <= WDT_CTRL_ADDR;
        wdata <= d;
        wr <= 1'b1;
        ta <= t;
        @(posedge clk);
        wr <= 1'b0;
        ta <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] e);
        @(posedge clk) addr <= WDT_CTRL_ADDR;
        repeat (2) @(posedge clk);
        #1 chk("control", e, rdata);
    endtask

    task automatic rst(input logic p);
        @(posedge clk);
        rst_n <= 1'b0;
        por_n <= p;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
    endtask

    task automatic conclude();
        if (err_total == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_gp();
        rd(8'h07);
        wrc(8'h81, 1'b0);
        rd(8'h07);
        wrc(8'h81, 1'b1);
        tk(255);
        rd(8'h81);
        tk(1);
        rd(8'hA1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            ie <= i[0];
            ge <= i[1];
            @(posedge clk);
            #1 chk("irq", {7'h00, i == 3}, {7'h00, irq});
        end
        wrc(8'h81, 1'b1);
        rd(8'h81);
        tk(256);
        rd(8'hA1);
        wrc(8'h01, 1'b1);
        tk(300);
        rd(8'h01);
    endtask

    // every remaining prescale code: clear, then 64 divided periods
    task automatic t_div();
        for (int k = 2; k < 8; k++)
        begin
            wrc(8'hC0 | 8'(k), 1'b1);
            // first tick only completes the clear
            tk(1);
            tk((WDT_TIMEOUT_TICKS << (k + 1)) - 1);
            rd(8'h80 | 8'(k));
            tk(1);
            rd(8'hA0 | 8'(k));
        end
        wrc(8'h01, 1'b1);
    endtask

    task automatic t_lp();
        rst(1'b1);
        rd(8'h01);
        wrc(8'h80, 1'b1);
        idle <= 1'b1;
        tk(100);
        rd(8'h80);
        @(posedge clk) idle <= 1'b0;
        wrc(8'h90, 1'b1);
        // partial count that power-down entry must discard
        tk(40);
        pd <= 1'b1;
        tk(63);
        rd(8'h90);
        tk(1);
        rd(8'hB0);
        chk("wakeups", 8'h01, 8'(wakes));
        @(posedge clk) pd <= 1'b0;
    endtask

    task automatic t_rm();
        mode <= 4'h0;
        rst(1'b1);
        tk(63);
        rd(8'h00);
        tk(1);
        rd(8'h20);
        tk(100);
        // a zero in the clear bit must not stop the grace count
        wrc(8'h00, 1'b1);
        tk(411);
        repeat (3) @(posedge clk);
        #1 chk("resets", 8'h00, 8'(resets));
        tk(1);
        repeat (3) @(posedge clk);
        #1 chk("resets", 8'h01, 8'(resets));
        rst(1'b1);
        rd(8'h08);
        rst(1'b0);
        rd(8'h07);
        wrc(8'h40, 1'b1);
        rd(8'h40);
        tk(1);
        rd(8'h00);
        // a clear after 40 counts must restart the full interval
        tk(40);
        wrc(8'h40, 1'b1);
        tk(64);
        rd(8'h00);
        tk(1);
        rd(8'h20);
        // grace armed; a one in the clear bit must stop it
        tk(500);
        wrc(8'h40, 1'b1);
        tk(100);
        repeat (3) @(posedge clk);
        #1 chk("resets", 8'h01, 8'(resets));
        @(posedge clk) mode <= 4'h5;
        rst(1'b1);
        idle <= 1'b1;
        tk(100);
        rd(8'h00);
        @(posedge clk) idle <= 1'b0;
    endtask

    initial
    begin
        {rst_n, por_n, tick, idle, pd, ta, ie, ge, wr} = '0;
        mode = WDT_MODE_GP;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        t_gp();
        t_div();
        // no clock divider here: power-down wake only runs with it at zero
        t_lp();
        t_rm();
        conclude();
    end

    // expected run is near 70000 cycles; this cuts a hang beyond it
    initial
    begin
        #900000;
        err_total++;
        conclude();
    end
endmodule
